// ==== cpm_pkg.sv ====
// constants, register map and carrier types of the clock and power mode control block
// assumes a single 125 MHz bus clock and an AHB-Lite master issuing single word transfers
`default_nettype none

package cpm_pkg;

    // ****************************************
    // register map, byte offsets
    // ****************************************
    localparam logic [7:0] OFS_POWER_CONTROL = 8'h00;
    localparam logic [7:0] OFS_POWER_MGMT    = 8'h04;
    localparam logic [7:0] OFS_EXT_IRQ_FLAG  = 8'h08;
    localparam logic [7:0] OFS_STATUS        = 8'h0C;

    // ****************************************
    // field positions
    // ****************************************
    localparam int PC_IDLE_BIT      = 0;
    localparam int PC_FAIL_EN_BIT   = 4;
    localparam int PC_FAIL_FLAG_BIT = 5;
    localparam int PM_SBK_BIT       = 5;
    localparam int PM_DIV_LSB       = 6;
    localparam int EX_RING_SEL_BIT  = 1;
    localparam int ST_RING_ACT_BIT  = 0;
    localparam int ST_FAIL_RST_BIT  = 1;
    localparam int ST_HOLD_BIT      = 2;

    // ****************************************
    // reset values and encodings
    // ****************************************
    localparam logic [1:0] DIV_1X           = 2'h2;
    localparam logic [1:0] DIV_1024         = 2'h3;
    localparam logic [5:0] IRQ_HIGH_ACTIVE  = 6'h14;
    localparam logic [31:0] RD_ZERO         = 32'h0000_0000;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ        = 125_000_000;
    localparam int FAIL_HZ       = 20_000;
    localparam int FAIL_CYCLES   = CLK_HZ / FAIL_HZ;
    localparam int WARM_PERIODS  = 65_536;
    localparam int MC_DIV_SLOW   = 1024;
    localparam int TIMER_DIV     = 12;
    localparam int SER_M2_SLOW   = 64;
    localparam int SER_M2_FAST   = 32;

    typedef enum logic [1:0] {
        CPM_RUN,
        CPM_STOPPED,
        CPM_WARM
    } cpm_stop_t;

    // one serial port as seen by the clock control
    typedef struct packed {
        logic rx_pin;
        logic rx_en;
        logic rx_busy;
        logic tx_busy;
    } cpm_ser_t;

endpackage

`default_nettype wire

// ==== cpm_top.sv ====
// clock divider, switchback, oscillator fail detect, stop recovery and idle control
// assumes all inputs synchronous to hclk; hclk keeps running while the crystal is lost
//
// What this block does
// - enabled fail detect holds reset on ring clock when crystal falls below 20 kHz
// - fail detect enable cleared only by software or power-fail reset
// - oscillator-fail reset sets fail flag; only software or power-on clears it
// - no fail reset while crystal is halted by stop mode
// - divider code 11b gives 1024 oscillator cycles per machine cycle
// - every reset returns divider code to 10b, divide by one
// - switchback acts only while switchback enable is set
// - enabled, permitted external interrupt level forces divide by one
// - serial receive falling edge or transmit activity also forces switchback
// - request for divide by 1024 while a serial port is active loads divider code 10b, divide by one
// - port inactive only with receive pin high and transmissions finished
// - switchback considered only in divide by 1024 mode
// - at ratio one or below timers keep divide by 12, serial 32 or 64
// - in slow mode timers and serial mode 2 scale with machine cycle
// - ring select runs from ring after stop until crystal warm, then switches
// - without ring select execution waits 65,536 crystal periods after stop
// - ring status bit shown; divider locked at 10b while ring in use
// - watchdog tick always from crystal, never ring
// - idle bit freezes instruction fetch; detectors and timers keep running
// - enabled interrupt or any reset ends idle and clears idle bit
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`default_nettype none

module cpm_top #(
    parameter int FAIL_CYCLES  = cpm_pkg::FAIL_CYCLES,
    parameter int WARM_PERIODS = cpm_pkg::WARM_PERIODS
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic [31:0]           hrdata,
    output logic                  hresp,
    input  wire logic             sys_rst,
    input  wire logic             pfail_rst,
    input  wire logic             xtal_edge,
    input  wire logic             stop_mode,
    input  wire logic [5:0]       ext_irq_in,
    input  wire logic [5:0]       irq_allowed,
    input  wire logic             irq_taken,
    input  wire cpm_pkg::cpm_ser_t ser0,
    input  wire cpm_pkg::cpm_ser_t ser1,
    input  wire logic             serial_baud_doubler,
    output logic                  osc_fail_rst,
    output logic                  ring_clk_sel,
    output logic                  cpu_hold,
    output logic                  cpu_idle,
    output logic                  mc_tick,
    output logic                  timer_tick,
    output logic                  ser_m2_tick,
    output logic                  wdt_tick
);

    localparam int GW = $clog2(FAIL_CYCLES + 1);
    localparam int WW = $clog2(WARM_PERIODS);

    if (FAIL_CYCLES < 2 || WARM_PERIODS < 2) begin : g_bad_param
        $error("cpm_top: FAIL_CYCLES and WARM_PERIODS must be at least 2");
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ****************************************
    // ahb-lite slave
    // ****************************************
    logic        wr_pend_reg;
    logic [7:0]  wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic        fail_en_reg;
    logic        fail_flag_reg;
    logic        idle_reg;
    logic [1:0]  div_reg;
    logic        sbk_reg;
    logic        ring_sel_reg;
    logic        ring_act_reg;
    logic        osc_rst_reg;
    logic        hold_reg;
    logic [31:0] rd_word;

    wire logic accept = hsel & htrans[1] & hready;

    function automatic logic wr_hit(input logic [7:0] ofs);
        return wr_pend_reg && (wr_addr_reg == ofs);
    endfunction

    // hsize is not checked: only whole word transfers reach this slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= accept & hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    always_comb begin
        rd_word = cpm_pkg::RD_ZERO;
        unique case (haddr[7:0])
            cpm_pkg::OFS_POWER_CONTROL: begin
                rd_word[cpm_pkg::PC_IDLE_BIT]      = idle_reg;
                rd_word[cpm_pkg::PC_FAIL_EN_BIT]   = fail_en_reg;
                rd_word[cpm_pkg::PC_FAIL_FLAG_BIT] = fail_flag_reg;
            end
            cpm_pkg::OFS_POWER_MGMT: begin
                rd_word[cpm_pkg::PM_SBK_BIT] = sbk_reg;
                rd_word[cpm_pkg::PM_DIV_LSB +: 2] = div_reg;
            end
            cpm_pkg::OFS_EXT_IRQ_FLAG: begin
                rd_word[cpm_pkg::EX_RING_SEL_BIT] = ring_sel_reg;
            end
            cpm_pkg::OFS_STATUS: begin
                rd_word[cpm_pkg::ST_RING_ACT_BIT] = ring_act_reg;
                rd_word[cpm_pkg::ST_FAIL_RST_BIT] = osc_rst_reg;
                rd_word[cpm_pkg::ST_HOLD_BIT]     = hold_reg;
            end
            default: rd_word = cpm_pkg::RD_ZERO;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= cpm_pkg::RD_ZERO;
        end else if (accept && !hwrite) begin
            hrdata_reg <= rd_word;
        end
    end

    // zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata = hrdata_reg;

    // ****************************************
    // oscillator fail detect
    // ****************************************
    logic [GW-1:0] gap_reg;
    cpm_pkg::cpm_stop_t state_reg;

    // gap counting only while running; halted or warming crystal is not a failure
    wire logic watch = (state_reg == cpm_pkg::CPM_RUN) && !stop_mode;
    wire logic fail_trip = fail_en_reg && watch && (gap_reg == GW'(FAIL_CYCLES)) && !osc_rst_reg;
    wire logic any_rst = sys_rst | pfail_rst | osc_rst_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_reg <= '0;
        end else if (xtal_edge || !watch) begin
            gap_reg <= '0;
        end else if (gap_reg != GW'(FAIL_CYCLES)) begin
            gap_reg <= gap_reg + GW'(1);
        end
    end

    // held until the crystal toggles again; ring clocks the chip meanwhile
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_rst_reg <= 1'b0;
        end else if (fail_trip) begin
            osc_rst_reg <= 1'b1;
        end else if (xtal_edge) begin
            osc_rst_reg <= 1'b0;
        end
    end

    // ****************************************
    // power control and external interrupt flag registers
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fail_en_reg <= 1'b0;
        end else if (pfail_rst) begin
            fail_en_reg <= 1'b0;
        end else if (wr_hit(cpm_pkg::OFS_POWER_CONTROL)) begin
            fail_en_reg <= hwdata[cpm_pkg::PC_FAIL_EN_BIT];
        end
    end

    // set beats a software clear in the same cycle; writing 1 keeps it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fail_flag_reg <= 1'b0;
        end else if (fail_trip) begin
            fail_flag_reg <= 1'b1;
        end else if (wr_hit(cpm_pkg::OFS_POWER_CONTROL)) begin
            fail_flag_reg <= fail_flag_reg & hwdata[cpm_pkg::PC_FAIL_FLAG_BIT];
        end
    end

    // wake wins over a simultaneous entry so a taken interrupt is never stranded
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_reg <= 1'b0;
        end else if (any_rst || irq_taken) begin
            idle_reg <= 1'b0;
        end else if (wr_hit(cpm_pkg::OFS_POWER_CONTROL)) begin
            idle_reg <= hwdata[cpm_pkg::PC_IDLE_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ring_sel_reg <= 1'b0;
        end else if (wr_hit(cpm_pkg::OFS_EXT_IRQ_FLAG)) begin
            ring_sel_reg <= hwdata[cpm_pkg::EX_RING_SEL_BIT];
        end
    end

    // ****************************************
    // divider and switchback
    // ****************************************
    logic [1:0] rx_prev_reg;

    function automatic logic ser_busy(input cpm_pkg::cpm_ser_t s);
        return !s.rx_pin || s.rx_busy || s.tx_busy;
    endfunction

    function automatic logic ser_kick(input cpm_pkg::cpm_ser_t s, input logic prev);
        return (s.rx_en && prev && !s.rx_pin) || s.tx_busy;
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_prev_reg <= 2'h3;
        end else begin
            rx_prev_reg <= {ser1.rx_pin, ser0.rx_pin};
        end
    end

    wire logic irq_hit = |(irq_allowed & ~(ext_irq_in ^ cpm_pkg::IRQ_HIGH_ACTIVE));
    wire logic ser_hit = ser_kick(ser0, rx_prev_reg[0]) | ser_kick(ser1, rx_prev_reg[1]);
    wire logic sb_fire = (div_reg == cpm_pkg::DIV_1024) && sbk_reg && (irq_hit || ser_hit);
    wire logic ser_active = ser_busy(ser0) | ser_busy(ser1);
    wire logic wr_pm = wr_hit(cpm_pkg::OFS_POWER_MGMT);
    wire logic [1:0] wr_div = hwdata[cpm_pkg::PM_DIV_LSB +: 2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sbk_reg <= 1'b0;
        end else if (any_rst) begin
            sbk_reg <= 1'b0;
        end else if (wr_pm) begin
            sbk_reg <= hwdata[cpm_pkg::PM_SBK_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= cpm_pkg::DIV_1X;
        end else if (any_rst) begin
            div_reg <= cpm_pkg::DIV_1X;
        end else if (ring_act_reg) begin
            div_reg <= cpm_pkg::DIV_1X;
        end else if (sb_fire) begin
            div_reg <= cpm_pkg::DIV_1X;
        end else if (wr_pm) begin
            if (wr_div == cpm_pkg::DIV_1024 && ser_active) begin
                div_reg <= cpm_pkg::DIV_1X;
            end else begin
                div_reg <= wr_div;
            end
        end
    end

    // ****************************************
    // machine cycle, timer and serial mode 2 strobes
    // ****************************************
    logic [9:0] mc_cnt_reg;
    logic [3:0] tmr_cnt_reg;
    logic [5:0] ser_cnt_reg;
    logic       mc_tick_reg;
    logic       timer_tick_reg;
    logic       ser_tick_reg;

    // ratios of one or below all give one machine cycle per hclk here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mc_cnt_reg  <= '0;
            mc_tick_reg <= 1'b0;
        end else if (div_reg != cpm_pkg::DIV_1024) begin
            mc_cnt_reg  <= '0;
            mc_tick_reg <= 1'b1;
        end else begin
            mc_cnt_reg  <= mc_cnt_reg + 10'd1;
            mc_tick_reg <= (mc_cnt_reg == 10'(cpm_pkg::MC_DIV_SLOW - 1));
        end
    end

    // counting machine cycles makes both ratio regimes fall out of one counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmr_cnt_reg    <= '0;
            timer_tick_reg <= 1'b0;
        end else if (mc_tick_reg) begin
            tmr_cnt_reg    <= (tmr_cnt_reg == 4'(cpm_pkg::TIMER_DIV - 1)) ? 4'd0
                              : tmr_cnt_reg + 4'd1;
            timer_tick_reg <= (tmr_cnt_reg == 4'(cpm_pkg::TIMER_DIV - 1));
        end else begin
            timer_tick_reg <= 1'b0;
        end
    end

    wire logic [5:0] ser_last = serial_baud_doubler ? 6'(cpm_pkg::SER_M2_FAST - 1)
                                                    : 6'(cpm_pkg::SER_M2_SLOW - 1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ser_cnt_reg  <= '0;
            ser_tick_reg <= 1'b0;
        end else if (mc_tick_reg) begin
            ser_cnt_reg  <= (ser_cnt_reg >= ser_last) ? 6'd0 : ser_cnt_reg + 6'd1;
            ser_tick_reg <= (ser_cnt_reg >= ser_last);
        end else begin
            ser_tick_reg <= 1'b0;
        end
    end

    // ****************************************
    // stop recovery and ring oscillator
    // ****************************************
    logic [WW-1:0] warm_cnt_reg;
    wire logic warm_done = xtal_edge && (warm_cnt_reg == WW'(WARM_PERIODS - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg    <= cpm_pkg::CPM_RUN;
            warm_cnt_reg <= '0;
            ring_act_reg <= 1'b0;
            hold_reg     <= 1'b0;
        end else begin
            unique case (state_reg)
                cpm_pkg::CPM_RUN: begin
                    if (stop_mode) begin
                        state_reg <= cpm_pkg::CPM_STOPPED;
                    end
                end
                cpm_pkg::CPM_STOPPED: begin
                    if (!stop_mode) begin
                        state_reg    <= cpm_pkg::CPM_WARM;
                        warm_cnt_reg <= '0;
                        ring_act_reg <= ring_sel_reg;
                        hold_reg     <= !ring_sel_reg;
                    end
                end
                cpm_pkg::CPM_WARM: begin
                    if (stop_mode) begin
                        state_reg <= cpm_pkg::CPM_STOPPED;
                    end else if (warm_done) begin
                        state_reg    <= cpm_pkg::CPM_RUN;
                        ring_act_reg <= 1'b0;
                        hold_reg     <= 1'b0;
                    end else if (xtal_edge) begin
                        warm_cnt_reg <= warm_cnt_reg + WW'(1);
                    end
                end
            endcase
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ring_clk_sel <= 1'b0;
            wdt_tick     <= 1'b0;
        end else begin
            ring_clk_sel <= ring_act_reg | osc_rst_reg | fail_trip;
            wdt_tick     <= xtal_edge;
        end
    end

    assign osc_fail_rst = osc_rst_reg;
    assign cpu_hold     = hold_reg;
    assign cpu_idle     = idle_reg;
    assign mc_tick      = mc_tick_reg;
    assign timer_tick   = timer_tick_reg;
    assign ser_m2_tick  = ser_tick_reg;

    // ****************************************
    // checks
    // ****************************************
    property p_fail_rst;
        fail_en_reg && watch && !xtal_edge && gap_reg == GW'(FAIL_CYCLES) |=> osc_rst_reg;
    endproperty
    a_fail_rst: assert property (p_fail_rst) else $error("fail reset missed");

    property p_fail_flag;
        $rose(osc_rst_reg) |-> fail_flag_reg;
    endproperty
    a_fail_flag: assert property (p_fail_flag) else $error("fail flag not set");

    property p_no_fail_in_stop;
        stop_mode |=> !$rose(osc_rst_reg);
    endproperty
    a_no_fail_in_stop: assert property (p_no_fail_in_stop) else $error("fail reset in stop");

    property p_div_reset;
        sys_rst || pfail_rst |=> div_reg == cpm_pkg::DIV_1X && !sbk_reg;
    endproperty
    a_div_reset: assert property (p_div_reset) else $error("divider not reset");

    property p_sbk_off;
        !sbk_reg && !wr_pm && !any_rst && !ring_act_reg |=> $stable(div_reg);
    endproperty
    a_sbk_off: assert property (p_sbk_off) else $error("divider moved without switchback");

    property p_switchback;
        div_reg == cpm_pkg::DIV_1024 && sbk_reg && irq_hit |=> div_reg == cpm_pkg::DIV_1X;
    endproperty
    a_switchback: assert property (p_switchback) else $error("switchback missed");

    property p_refuse;
        wr_pm && wr_div == cpm_pkg::DIV_1024 && ser_active |=> div_reg != cpm_pkg::DIV_1024;
    endproperty
    a_refuse: assert property (p_refuse) else $error("slow mode entered while busy");

    property p_ring_lock;
        ring_act_reg && $past(ring_act_reg) |-> div_reg == cpm_pkg::DIV_1X;
    endproperty
    a_ring_lock: assert property (p_ring_lock) else $error("divider moved on ring");

    property p_ring_off;
        ring_act_reg && warm_done && !stop_mode |=> !ring_act_reg ##1 !ring_clk_sel || osc_rst_reg;
    endproperty
    a_ring_off: assert property (p_ring_off) else $error("ring not released");

    property p_timer_gap;
        timer_tick_reg |=> (!timer_tick_reg)[*8];
    endproperty
    a_timer_gap: assert property (p_timer_gap) else $error("timer tick too early");

    property p_idle_wake;
        irq_taken |=> !idle_reg;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle not ended");

    property p_wdt;
        xtal_edge |=> wdt_tick ##1 (wdt_tick == $past(xtal_edge));
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog tick not from crystal");

endmodule

`default_nettype wire

// ==== cpm_xtal_model.sv ====
// crystal oscillator stand-in for the clock and power mode control block
// assumes hclk is the bench clock; one edge pulse per crystal period
`default_nettype none
module cpm_xtal_model #(
    parameter int PERIOD = 4
) (
    input  wire logic hclk,
    input  wire logic run,
    input  wire logic stop_mode,
    output logic      xtal_edge
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // ****************************************
    // oscillator
    // ****************************************
    // crystal is dead in stop mode, so no edges reach the detector
    always_ff @(posedge hclk) begin
        if (!run || stop_mode) begin
            cnt       <= 0;
            xtal_edge <= 1'b0;
        end else begin
            cnt       <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            xtal_edge <= (cnt == PERIOD - 1);
        end
    end
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the clock and power mode control block
// assumes zero-wait AHB-Lite slave and short fail and warm-up counts
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] PC = cpm_pkg::OFS_POWER_CONTROL;
    localparam logic [7:0] PM = cpm_pkg::OFS_POWER_MGMT;
    localparam logic [7:0] EX = cpm_pkg::OFS_EXT_IRQ_FLAG;
    localparam logic [7:0] ST = cpm_pkg::OFS_STATUS;
    localparam logic [5:0] HA = cpm_pkg::IRQ_HIGH_ACTIVE;
    logic             hclk, hresetn, hsel, hwrite, sys_rst, pfail_rst, xtal_run, stop_mode;
    logic             irq_taken, hreadyout, hresp, xtal_edge, osc_fail_rst, ring_clk_sel;
    logic             cpu_hold, cpu_idle, mc_tick, timer_tick, ser_m2_tick, wdt_tick, baud_dbl;
    logic [31:0]      haddr, hwdata, hrdata, q;
    logic [1:0]       htrans;
    logic [5:0]       ext_irq_in, irq_allowed;
    cpm_pkg::cpm_ser_t ser0, ser1;
    int               error_cnt, num_checks, m, t, s, w;

    cpm_top #(.FAIL_CYCLES(20), .WARM_PERIODS(16)) cpm_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sys_rst(sys_rst),
        .pfail_rst(pfail_rst), .xtal_edge(xtal_edge), .stop_mode(stop_mode),
        .ext_irq_in(ext_irq_in), .irq_allowed(irq_allowed), .irq_taken(irq_taken),
        .ser0(ser0), .ser1(ser1), .serial_baud_doubler(baud_dbl), .osc_fail_rst(osc_fail_rst),
        .ring_clk_sel(ring_clk_sel), .cpu_hold(cpu_hold), .cpu_idle(cpu_idle),
        .mc_tick(mc_tick), .timer_tick(timer_tick), .ser_m2_tick(ser_m2_tick),
        .wdt_tick(wdt_tick));
    cpm_xtal_model cpm_xtal_model_inst (
        .hclk(hclk), .run(xtal_run), .stop_mode(stop_mode), .xtal_edge(xtal_edge));

    // ****************************************
    // bus and check helpers
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h00_0000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, e, q);
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic ticks(input int n);
        m = 0;
        t = 0;
        s = 0;
        w = 0;
        repeat (n) begin
            @(posedge hclk);
            m += int'(mc_tick);
            t += int'(timer_tick);
            s += int'(ser_m2_tick);
            w += int'(wdt_tick);
        end
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_and_rates();
        rc(PM, 32'h0000_0080, "div");
        rc(8'h10, 32'h0000_0000, "unmapped");
        ticks(128);
        chk("timer ticks", 32'h0000_000A, 32'(t));
        chk("ser ticks", 32'h0000_0002, 32'(s));
        chk("wdt ticks", 32'h0000_0020, 32'(w));
        baud_dbl <= 1'b1;
        ticks(128);
        chk("fast ser ticks", 32'h0000_0004, 32'(s));
        baud_dbl <= 1'b0;
        wr(PM, 32'h0000_00C0);
        rc(PM, 32'h0000_00C0, "slow div");
        ticks(2048);
        chk("slow mc ticks", 32'h0000_0002, 32'(m));
        ext_irq_in <= HA;
        cyc(3);
        rc(PM, 32'h0000_00C0, "no sbk");
        ext_irq_in <= ~HA;
    endtask
    task automatic t_switchback();
        for (int i = 0; i < 6; i++) begin
            wr(PM, 32'h0000_00E0);
            ext_irq_in[i] <= HA[i];
            cyc(2);
            ext_irq_in <= ~HA;
            rc(PM, 32'h0000_00A0, "irq sbk");
        end
        irq_allowed <= 6'h00;
        wr(PM, 32'h0000_00E0);
        ext_irq_in <= HA;
        cyc(2);
        rc(PM, 32'h0000_00E0, "masked irq");
        irq_allowed <= 6'h3F;
        wr(PM, 32'h0000_0020);
        rc(PM, 32'h0000_0020, "div 00 irq");
        ext_irq_in <= ~HA;
    endtask
    task automatic t_serial();
        wr(PM, 32'h0000_00E0);
        ser0.tx_busy <= 1'b1;
        cyc(2);
        rc(PM, 32'h0000_00A0, "tx sbk");
        wr(PM, 32'h0000_00E0);
        rc(PM, 32'h0000_00A0, "tx refuse");
        ser0.tx_busy <= 1'b0;
        ser1.rx_en <= 1'b1;
        wr(PM, 32'h0000_00E0);
        ser1.rx_pin <= 1'b0;
        cyc(2);
        rc(PM, 32'h0000_00A0, "rx sbk");
        wr(PM, 32'h0000_00E0);
        rc(PM, 32'h0000_00A0, "rx low refuse");
        ser1 <= 4'h8;
    endtask
    task automatic t_fail_and_stop();
        wr(PC, 32'h0000_0010);
        wr(PM, 32'h0000_00C0);
        xtal_run <= 1'b0;
        cyc(26);
        chk("fail rst", 32'h0000_0001, {31'h0, osc_fail_rst});
        xtal_run <= 1'b1;
        cyc(12);
        chk("fail rst end", 32'h0000_0000, {31'h0, osc_fail_rst});
        rc(PC, 32'h0000_0030, "fail flag");
        rc(PM, 32'h0000_0080, "div after fail");
        wr(PC, 32'h0000_0010);
        rc(PC, 32'h0000_0010, "flag cleared");
        stop_mode <= 1'b1;
        cyc(40);
        chk("stop no fail", 32'h0000_0000, {31'h0, osc_fail_rst});
        stop_mode <= 1'b0;
        cyc(52);
        chk("hold", 32'h0000_0001, {31'h0, cpu_hold});
        cyc(20);
        chk("hold end", 32'h0000_0000, {31'h0, cpu_hold});
        wr(EX, 32'h0000_0002);
        stop_mode <= 1'b1;
        cyc(4);
        stop_mode <= 1'b0;
        cyc(3);
        chk("ring", 32'h0000_0001, {31'h0, ring_clk_sel});
        rc(ST, 32'h0000_0001, "status ring");
        wr(PM, 32'h0000_00C0);
        rc(PM, 32'h0000_0080, "ring lock");
        cyc(72);
        chk("ring off", 32'h0000_0000, {31'h0, ring_clk_sel});
        wr(PM, 32'h0000_00C0);
        rc(PM, 32'h0000_00C0, "unlocked");
    endtask
    task automatic t_idle_and_resets();
        wr(PC, 32'h0000_0011);
        cyc(1);
        chk("idle", 32'h0000_0001, {31'h0, cpu_idle});
        irq_taken <= 1'b1;
        cyc(1);
        irq_taken <= 1'b0;
        cyc(2);
        chk("idle end", 32'h0000_0000, {31'h0, cpu_idle});
        wr(PC, 32'h0000_0011);
        wr(PM, 32'h0000_00E0);
        sys_rst <= 1'b1;
        cyc(1);
        sys_rst <= 1'b0;
        rc(PC, 32'h0000_0010, "sys rst pc");
        rc(PM, 32'h0000_0080, "sys rst div");
        pfail_rst <= 1'b1;
        cyc(1);
        pfail_rst <= 1'b0;
        rc(PC, 32'h0000_0000, "pfail pc");
    endtask

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    initial begin
        cyc(20000);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        {hresetn, hsel, hwrite, sys_rst, pfail_rst, stop_mode, irq_taken, baud_dbl} = 8'h00;
        {haddr, hwdata, htrans} = 66'h0;
        xtal_run = 1'b1;
        ext_irq_in = ~HA;
        irq_allowed = 6'h3F;
        ser0 = 4'h8;
        ser1 = 4'h8;
        cyc(6);
        hresetn <= 1'b1;
        cyc(1);
        t_reset_and_rates();
        t_switchback();
        t_serial();
        t_fail_and_stop();
        t_idle_and_resets();
        tally_and_finish();
    end
endmodule
`default_nettype wire
